// File: design/supply_cmp_pkg.sv
package supply_cmp_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_INPUT_SEL = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_INT_ENABLE = 12'h00c;
   localparam logic [11:0] OFS_INT_FLAGS = 12'h010;
   localparam logic [11:0] OFS_FLAG_SET = 12'h014;
   localparam logic [11:0] OFS_FLAG_CLEAR = 12'h018;

   // Control register field positions.
   localparam int CTL_ENABLE = 0;
   localparam int CTL_IDLE_VAL = 2;
   localparam int CTL_HYST = 4;
   localparam int CTL_WARM_LO = 8;
   localparam int CTL_WARM_HI = 10;
   localparam int CTL_RISE = 16;
   localparam int CTL_FALL = 17;
   localparam int CTL_BIAS_LO = 24;
   localparam int CTL_BIAS_HI = 27;
   localparam int CTL_HALVE = 30;

   // Input selection field positions.
   localparam int SEL_TRIG_LO = 0;
   localparam int SEL_TRIG_HI = 5;
   localparam int SEL_LPREF = 8;

   // Status and interrupt bit positions.
   localparam int STA_ACTIVE = 0;
   localparam int STA_RESULT = 1;
   localparam int IRQ_EDGE = 0;
   localparam int IRQ_WARMUP = 1;
   localparam int IRQ_BITS = 2;

   // Reset values.
   localparam logic [3:0] BIAS_LEVEL_RST = 4'h7;
   localparam logic BIAS_HALVE_RST = 1'b1;
   localparam logic [2:0] WARMUP_SEL_RST = 3'h0;

   // Warm-up length is WARMUP_BASE shifted left by the select field.
   localparam int WARM_CNT_W = 10;
   localparam logic [WARM_CNT_W-1:0] WARMUP_BASE = 10'h004;
   localparam logic [WARM_CNT_W-1:0] WARM_ONE = 10'h001;
endpackage

// File: design/warmup_if.sv
`timescale 1ns/100ps
interface warmup_if;
   import supply_cmp_pkg::*;
   logic enable;
   logic [2:0] select;
   logic active;
   logic done;
   modport ctrl (output enable, output select, input active, input done);
   modport timer (input enable, input select, output active, output done);
endinterface

// File: design/warmup_timer.sv
`timescale 1ns/100ps
module warmup_timer
   import supply_cmp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   warmup_if.timer wu
);
   logic [WARM_CNT_W-1:0] count_reg;
   logic [WARM_CNT_W-1:0] count_next;
   logic active_reg;
   logic done_reg;
   wire logic [WARM_CNT_W-1:0] length = WARMUP_BASE << wu.select;
   wire logic last = (count_reg == length - WARM_ONE);
   wire logic finish = wu.enable && !active_reg && last;

   // Count up while enabled and not yet active; a disable restarts the count.
   assign count_next = (!wu.enable || active_reg) ? '0 : count_reg + WARM_ONE;
   assign wu.active = active_reg;
   assign wu.done = done_reg;

   // Active rises after the full length and falls as soon as enable drops.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_reg <= '0;
         active_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         active_reg <= wu.enable && (active_reg || last);
         done_reg <= finish;
      end
   end
endmodule

// File: design/supply_cmp_ctrl.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - Seven word registers at offsets 0x000 to 0x018 are decoded from the base.
// - Writing ones to the flag-set register sets those flags; zeros do nothing.
// - Writing ones to the flag-clear register clears those flags; zeros do nothing.
// - Control holds bias level bits 27:24 reset 7 and bias halve bit 30 reset 1.
// - Falling-edge sense bit 17 lets falling comparator edges set the edge flag.
// - Rising-edge sense bit 16 lets rising comparator edges set the edge flag.
// - Warm-up select bits 10:8 give a warm-up of four shifted left by the field.
// - Once enabled and warmed up the active status bit is set.
// - While disabled or warming, active is clear and output shows the idle value.
// - Interrupt is raised when an enabled edge or warm-up flag is set.
// - The warm-up flag is set when a warm-up sequence finishes.
module supply_cmp_ctrl
   import supply_cmp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_raw_i,
   output logic cmp_enable_o,
   output logic [3:0] bias_level_o,
   output logic bias_halve_o,
   output logic hysteresis_on_o,
   output logic [5:0] trig_level_o,
   output logic low_power_ref_o,
   output logic compare_result_o,
   output logic irq_o
);
   // Bundle of signals shared with the warm-up timer. The control side drives
   // enable and select from the control register, and the timer answers with
   // the active level and a one-cycle done pulse at the end of each warm-up.
   warmup_if wu ();

   // Stored control fields. Each one except the interrupt flags is a plain read/write flop that only a
   // write to the control, input selection or interrupt enable word changes.
   // Software should change them only while the comparator is disabled; the
   // logic does not enforce that, so a change while active takes effect at once.
   logic enable_reg;
   logic idle_output_value_reg;
   logic hysteresis_on_reg;
   logic [2:0] warmup_select_reg;
   logic rise_edge_sense_reg;
   logic fall_edge_sense_reg;
   logic [3:0] bias_level_reg;
   logic bias_halve_reg;
   logic [5:0] trig_level_reg;
   logic low_power_ref_reg;
   logic [IRQ_BITS-1:0] int_enable_reg;
   logic [IRQ_BITS-1:0] flags_reg;
   logic [IRQ_BITS-1:0] flags_next;

   // Comparator path and bus answer registers. The raw comparator level is
   // asynchronous to the core clock, so it passes two flops before the result
   // register or the edge detectors look at it. The bus answer is held in flops
   // so that every output of this block comes straight from a register.
   logic cmp_meta_reg;
   logic cmp_sync_reg;
   logic result_reg;
   logic result_next;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;

   // Bus phase decode: the read is captured in setup, writes land at the access edge.
   // A write strobe needs the registered ready as well, so a write takes effect
   // exactly once, at the single edge where the master sees ready high. The
   // address compare is on the full byte address, so a misaligned address never
   // aliases onto a register; it falls out as unmapped and answers with an error.
   // Writes to the read-only status and flag words match no strobe and are lost.
   wire logic setup = psel && !penable;
   wire logic wr_take = psel && penable && pready_reg && pwrite;
   wire logic hit_ctl = (paddr == OFS_CONTROL);
   wire logic hit_sel = (paddr == OFS_INPUT_SEL);
   wire logic hit_sta = (paddr == OFS_STATUS);
   wire logic hit_ien = (paddr == OFS_INT_ENABLE);
   wire logic hit_flg = (paddr == OFS_INT_FLAGS);
   wire logic hit_set = (paddr == OFS_FLAG_SET);
   wire logic hit_clr = (paddr == OFS_FLAG_CLEAR);
   wire logic mapped = hit_ctl || hit_sel || hit_sta || hit_ien || hit_flg
                       || hit_set || hit_clr;
   wire logic wr_ctl = wr_take && hit_ctl;
   wire logic wr_sel = wr_take && hit_sel;
   wire logic wr_ien = wr_take && hit_ien;
   wire logic wr_set = wr_take && hit_set;
   wire logic wr_clr = wr_take && hit_clr;

   // Read images; reserved positions stay zero.
   // Every image starts from zero and only the implemented fields are laid on
   // top, so reserved bits read back as zero whatever software wrote to them.
   // The status image shows the live active level and the visible result.
   logic [31:0] ctl_image;
   logic [31:0] sel_image;
   logic [31:0] sta_image;
   logic [31:0] ien_image;
   logic [31:0] flg_image;
   logic [31:0] read_mux;

   always_comb begin
      ctl_image = '0;
      ctl_image[CTL_ENABLE] = enable_reg;
      ctl_image[CTL_IDLE_VAL] = idle_output_value_reg;
      ctl_image[CTL_HYST] = hysteresis_on_reg;
      ctl_image[CTL_WARM_HI:CTL_WARM_LO] = warmup_select_reg;
      ctl_image[CTL_RISE] = rise_edge_sense_reg;
      ctl_image[CTL_FALL] = fall_edge_sense_reg;
      ctl_image[CTL_BIAS_HI:CTL_BIAS_LO] = bias_level_reg;
      ctl_image[CTL_HALVE] = bias_halve_reg;
      sel_image = '0;
      sel_image[SEL_TRIG_HI:SEL_TRIG_LO] = trig_level_reg;
      sel_image[SEL_LPREF] = low_power_ref_reg;
      sta_image = '0;
      sta_image[STA_ACTIVE] = wu.active;
      sta_image[STA_RESULT] = result_reg;
      ien_image = '0;
      ien_image[IRQ_BITS-1:0] = int_enable_reg;
      flg_image = '0;
      flg_image[IRQ_BITS-1:0] = flags_reg;
   end

   // Read data selection; write-only and unmapped words read as zero.
   // The flag set and flag clear words are write-only strobes and have no
   // storage of their own, so reading them returns zero. The address decode is
   // one-hot, so the order of the chain only matters for readability.
   assign read_mux = hit_ctl ? ctl_image :
                     hit_sel ? sel_image :
                     hit_sta ? sta_image :
                     hit_ien ? ien_image :
                     hit_flg ? flg_image : '0;

   // Warm-up timer hookup.
   // The timer sees the stored enable and select fields directly. Dropping the
   // enable bit clears its count and its active level, so the next enable always
   // waits for a full warm-up before the comparator result is trusted.
   assign wu.enable = enable_reg;
   assign wu.select = warmup_select_reg;

   warmup_timer u_warmup (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .wu(wu)
   );

   // The visible output is the synchronised comparator when active, else the idle value.
   // Edges are found between the next visible value and the registered one, so
   // the edge flag is set at the same clock edge at which the result changes.
   // Changes of the forced idle value count as edges too; picking the idle value
   // equal to the expected settled level avoids a spurious edge when warm-up ends.
   // After reset both the result and the idle value are low, so no false edge
   // follows the release of reset.
   assign result_next = wu.active ? cmp_sync_reg : idle_output_value_reg;
   wire logic rise_seen = rise_edge_sense_reg && result_next && !result_reg;
   wire logic fall_seen = fall_edge_sense_reg && !result_next && result_reg;

   // Hardware and flag-set sources win over a simultaneous clear.
   // Clearing is applied first and setting second, so an event that lands in
   // the same cycle as a clear is never lost. Software that clears a flag and
   // then finds it set again knows that a fresh event has arrived.
   // Zero bits in the set and clear words leave their flags as they are.
   logic [IRQ_BITS-1:0] hw_set;
   logic [IRQ_BITS-1:0] sw_set;
   logic [IRQ_BITS-1:0] sw_clr;

   always_comb begin
      hw_set = '0;
      hw_set[IRQ_EDGE] = rise_seen || fall_seen;
      hw_set[IRQ_WARMUP] = wu.done;
      sw_set = wr_set ? pwdata[IRQ_BITS-1:0] : '0;
      sw_clr = wr_clr ? pwdata[IRQ_BITS-1:0] : '0;
      flags_next = (flags_reg & ~sw_clr) | sw_set | hw_set;
   end

   // Comparator synchroniser and result register.
   // Only the second flop reads the first, which keeps the metastable node
   // away from any other logic. The result register adds one more cycle, so
   // the visible output follows the raw input three clock cycles later.
   // The response time of the analog part itself comes on top of this.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
         result_reg <= 1'b0;
      end else begin
         cmp_meta_reg <= cmp_raw_i;
         cmp_sync_reg <= cmp_meta_reg;
         result_reg <= result_next;
      end
   end

   // Control register.
   // A write replaces every implemented field at once; there are no byte
   // strobes. The bias level and the halving bit leave this block unchanged as
   // settings for the analog bias generator, which decodes them into a current.
   // Reserved bits of the write word are simply not stored.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         enable_reg <= 1'b0;
         idle_output_value_reg <= 1'b0;
         hysteresis_on_reg <= 1'b0;
         warmup_select_reg <= WARMUP_SEL_RST;
         rise_edge_sense_reg <= 1'b0;
         fall_edge_sense_reg <= 1'b0;
         bias_level_reg <= BIAS_LEVEL_RST;
         bias_halve_reg <= BIAS_HALVE_RST;
      end else if (wr_ctl) begin
         enable_reg <= pwdata[CTL_ENABLE];
         idle_output_value_reg <= pwdata[CTL_IDLE_VAL];
         hysteresis_on_reg <= pwdata[CTL_HYST];
         warmup_select_reg <= pwdata[CTL_WARM_HI:CTL_WARM_LO];
         rise_edge_sense_reg <= pwdata[CTL_RISE];
         fall_edge_sense_reg <= pwdata[CTL_FALL];
         bias_level_reg <= pwdata[CTL_BIAS_HI:CTL_BIAS_LO];
         bias_halve_reg <= pwdata[CTL_HALVE];
      end
   end

   // Input selection and interrupt enable registers.
   // The trigger level and the low-power reference bit go straight to the
   // analog front end. The enable word masks the level interrupt only; the
   // flags themselves are set whether or not their source is enabled.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trig_level_reg <= '0;
         low_power_ref_reg <= 1'b0;
         int_enable_reg <= '0;
      end else begin
         if (wr_sel) begin
            trig_level_reg <= pwdata[SEL_TRIG_HI:SEL_TRIG_LO];
            low_power_ref_reg <= pwdata[SEL_LPREF];
         end
         if (wr_ien) begin
            int_enable_reg <= pwdata[IRQ_BITS-1:0];
         end
      end
   end

   // Sticky flags and the level interrupt.
   // The interrupt is computed from the next flag value, so it rises at the
   // same edge as the flag that causes it and stays high until software
   // clears the flag or masks it. A change of the enable word reaches the
   // interrupt one edge after the write.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         irq_reg <= |(flags_next & int_enable_reg);
      end
   end

   // Bus answer: one wait-free access phase after every setup cycle.
   // Ready is a one-cycle pulse that follows each setup cycle, so back-to-back
   // transfers need no extra idle cycle. Read data is captured at the setup
   // edge and stands through the access cycle; a write answers with zero data.
   // The error flag stands with ready for any address outside the map and the
   // access then has no effect. The master must not hold penable low for more
   // than one setup cycle, or a second answer would be produced.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && !mapped;
         if (setup) begin
            prdata_reg <= pwrite ? '0 : read_mux;
         end
      end
   end

   // Outputs straight from flip-flops.
   // Each port is a plain copy of a register, with no logic in between, so
   // the analog front end and the interrupt controller see glitch-free levels
   // and the timing from this block is one flop to the pin.
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign cmp_enable_o = enable_reg;
   assign bias_level_o = bias_level_reg;
   assign bias_halve_o = bias_halve_reg;
   assign hysteresis_on_o = hysteresis_on_reg;
   assign trig_level_o = trig_level_reg;
   assign low_power_ref_o = low_power_ref_reg;
   assign compare_result_o = result_reg;
   assign irq_o = irq_reg;
endmodule

// File: tb/supply_cmp_ctrl_asserts.sv
`timescale 1ns/100ps
module supply_cmp_ctrl_asserts
   import supply_cmp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cmp_enable_o,
   input wire logic [3:0] bias_level_o,
   input wire logic bias_halve_o,
   input wire logic [5:0] trig_level_o,
   input wire logic irq_o
);
   // Every check runs on the core clock and rests during reset.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [31:0] wdata_q;
   // Named decodes of the bus phases.
   wire logic setup = psel && !penable;
   wire logic wr_done = psel && penable && pready && pwrite;
   // Keeps the write data of the last edge for the one-cycle-late checks.
   always_ff @(posedge core_clk_i) begin
      wdata_q <= pwdata;
   end
   property p_ready_one; setup |=> pready ##1 !pready; endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready not a one cycle answer");
   property p_err_map; setup && paddr > OFS_FLAG_CLEAR |=> pready && pslverr; endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped access without error");
   property p_err_ok; setup && paddr <= OFS_FLAG_CLEAR && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   a_err_ok: assert property (p_err_ok) else $error("mapped access gave an error");
   property p_bias; wr_done && paddr == OFS_CONTROL |=>
      bias_level_o == wdata_q[27:24] && bias_halve_o == wdata_q[30]; endproperty
   a_bias: assert property (p_bias) else $error("bias fields not written");
   property p_cfg_hold; !wr_done |=> $stable(bias_level_o) && $stable(bias_halve_o); endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("bias changed without a write");
   property p_enable; wr_done && paddr == OFS_CONTROL |=> cmp_enable_o == wdata_q[0]; endproperty
   a_enable: assert property (p_enable) else $error("enable bit not written");
   property p_trig; wr_done && paddr == OFS_INPUT_SEL |=> trig_level_o == wdata_q[5:0];
   endproperty
   a_trig: assert property (p_trig) else $error("trigger level not written");
   property p_irq_off; wr_done && paddr == OFS_INT_ENABLE && pwdata[1:0] == 2'h0 |=> ##1 !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq high with all sources masked");
endmodule
bind supply_cmp_ctrl supply_cmp_ctrl_asserts chk_i (.core_clk_i, .arst_n_i, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .cmp_enable_o, .bias_level_o, .bias_halve_o,
   .trig_level_o, .irq_o);

// File: tb/supply_comparator_control_test.sv
`timescale 1ns/100ps
module supply_comparator_control_test
   import supply_cmp_pkg::*;
;
   logic core_clk_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic cmp_raw_i = 1'b0, pready, pslverr, cmp_enable_o, bias_halve_o, er;
   logic hysteresis_on_o, low_power_ref_o, compare_result_o, irq_o;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] bias_level_o;
   logic [5:0] trig_level_o;
   int err_total = 0, checked = 0;
   supply_cmp_ctrl dut (.core_clk_i, .arst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cmp_raw_i, .cmp_enable_o, .bias_level_o, .bias_halve_o,
      .hysteresis_on_o, .trig_level_o, .low_power_ref_o, .compare_result_o, .irq_o);
   // The 40 MHz core clock.
   initial forever #12.5 core_clk_i = ~core_clk_i;
   // Prints the counts and the verdict, then stops.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; the request holds until pready is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_total++;
         test_done();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // Register map, flags, interrupt, warm-up and edge sequences in turn.
   initial begin
      wait_clk(5);
      arst_n_i <= 1'b1;
      rchk(OFS_CONTROL, 32'h47000000, "ctrl reset");
      chk("mapped err", {31'h0, er}, 32'h0);
      chk("bias level reset", {28'h0, bias_level_o}, 32'h7);
      chk("bias halve reset", {31'h0, bias_halve_o}, 32'h1);
      apb(1'b1, OFS_CONTROL, 32'h4f030714);
      rchk(OFS_CONTROL, 32'h4f030714, "ctrl fields");
      chk("bias level", {28'h0, bias_level_o}, 32'hf);
      chk("hysteresis", {31'h0, hysteresis_on_o}, 32'h1);
      chk("enable pin", {31'h0, cmp_enable_o}, 32'h0);
      chk("idle result", {31'h0, compare_result_o}, 32'h1);
      apb(1'b1, OFS_INPUT_SEL, 32'h0000013f);
      rchk(OFS_INPUT_SEL, 32'h0000013f, "input select");
      chk("trig level", {26'h0, trig_level_o}, 32'h3f);
      chk("low power ref", {31'h0, low_power_ref_o}, 32'h1);
      apb(1'b0, 12'h01c, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      apb(1'b1, OFS_CONTROL, 32'h0);
      apb(1'b1, OFS_FLAG_SET, 32'h3);
      rchk(OFS_INT_FLAGS, 32'h3, "flag set");
      apb(1'b1, OFS_FLAG_CLEAR, 32'h1);
      rchk(OFS_INT_FLAGS, 32'h2, "flag clear");
      apb(1'b1, OFS_INT_ENABLE, 32'h1);
      wait_clk(2);
      chk("irq masked", {31'h0, irq_o}, 32'h0);
      apb(1'b1, OFS_INT_ENABLE, 32'h2);
      wait_clk(2);
      chk("irq raised", {31'h0, irq_o}, 32'h1);
      apb(1'b1, OFS_FLAG_CLEAR, 32'h3);
      wait_clk(2);
      chk("irq cleared", {31'h0, irq_o}, 32'h0);
      apb(1'b1, OFS_INT_ENABLE, 32'h0);
      apb(1'b1, OFS_CONTROL, 32'h00010201);
      wait_clk(12);
      rchk(OFS_STATUS, 32'h0, "warming");
      wait_clk(6);
      rchk(OFS_STATUS, 32'h1, "active");
      rchk(OFS_INT_FLAGS, 32'h2, "warm flag");
      cmp_raw_i <= 1'b1;
      wait_clk(6);
      rchk(OFS_STATUS, 32'h3, "result");
      chk("result pin", {31'h0, compare_result_o}, 32'h1);
      rchk(OFS_INT_FLAGS, 32'h3, "rise edge");
      apb(1'b1, OFS_FLAG_CLEAR, 32'h3);
      cmp_raw_i <= 1'b0;
      wait_clk(6);
      rchk(OFS_INT_FLAGS, 32'h0, "fall unsensed");
      apb(1'b1, OFS_CONTROL, 32'h00020201);
      cmp_raw_i <= 1'b1;
      wait_clk(6);
      rchk(OFS_INT_FLAGS, 32'h0, "rise unsensed");
      cmp_raw_i <= 1'b0;
      wait_clk(6);
      rchk(OFS_INT_FLAGS, 32'h1, "fall edge");
      apb(1'b1, OFS_CONTROL, 32'h0);
      rchk(OFS_STATUS, 32'h0, "disabled");
      apb(1'b1, OFS_CONTROL, 32'h00000201);
      rchk(OFS_STATUS, 32'h0, "restart");
      apb(1'b1, OFS_CONTROL, 32'h0);
      apb(1'b1, OFS_CONTROL, 32'h00000201);
      wait_clk(8);
      rchk(OFS_STATUS, 32'h0, "fresh count");
      wait_clk(8);
      rchk(OFS_STATUS, 32'h1, "rewarmed");
      test_done();
   end
endmodule
